// >>> logic/bps_pkg.sv
// Purpose: constants and types for the byte port with slave control
// Assumes: plain register port, 8-bit data
// Notes: offsets are register indices on the plain port
package bps_pkg;
  localparam logic [3:0] ADDR_PIN_D = 4'h0;
  localparam logic [3:0] ADDR_HOLD_D = 4'h1;
  localparam logic [3:0] ADDR_DIR_D = 4'h2;
  localparam logic [3:0] ADDR_PIN_E = 4'h3;
  localparam logic [3:0] ADDR_HOLD_E = 4'h4;
  localparam logic [3:0] ADDR_DIR_E = 4'h5;
  localparam logic [3:0] ADDR_ANALOG = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam int BIT_IBF = 7;
  localparam int BIT_OBF = 6;
  localparam int BIT_INPUT_OVERRUN_FLAG = 5;
  localparam int BIT_MODE = 4;
  localparam logic [7:0] RST_DIR_D = 8'hFF;
  localparam logic [2:0] RST_DIR_E = 3'h7;
  localparam logic [2:0] RST_ANALOG = 3'h7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int IRQ_WRITE = 0;
  localparam int IRQ_READ = 1;
  localparam int IRQ_OVERRUN = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bps_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } bps_pad8_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } bps_pad3_t;
endpackage : bps_pkg

// >>> logic/bps_port.sv
// Purpose: port D (8 bit) and port E (3 bit) with parallel slave mode
// Assumes: pins synchronous to clk_i; one clock domain
// Notes: port E carries active-low read, write and select in slave mode
//
// Contract
// - port E direction bit one makes its pin an input, driver off
// - port E direction bit zero drives pin from output hold latch
// - port E latch reads and writes return latch value, not pins
// - port E pins set analog read as zero
// - port E direction still gates drivers while pins are analog
// - after reset all port E pins are analog inputs
// - direction_e bit 7 shows input byte waiting, read-only
// - direction_e bit 6 shows output byte not yet read, read-only
// - bit 5 sets on external write over unread byte, software clears
// - direction_e bit 4 selects slave port mode
// - direction_e bit 3 always reads zero
// - slave read when read strobe and select both low
// - slave write when write strobe and select both low
// - select low means chosen, high blocks all slave transfers
// - port D pin n is slave bus bit n
// - write captured when select and write first both seen low
// - read done when select and read first both seen low
// - software sets port E inputs and digital before slave use
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module bps_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire bps_pkg::bps_req_t req_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  // port D pins
  input wire logic [7:0] pad_d_i,
  output bps_pkg::bps_pad8_t pad_d_o,
  // port E pins
  input wire logic [2:0] pad_e_i,
  output bps_pkg::bps_pad3_t pad_e_o
);
  import bps_pkg::*;

  logic [7:0] hold_d;
  logic [7:0] dir_d;
  logic [7:0] in_buf;
  logic [2:0] hold_e;
  logic [2:0] dir_e;
  logic [2:0] analog;
  logic mode;
  logic input_full_flag;
  logic output_full_flag;
  logic input_overrun_flag;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic wr_act_q;
  logic rd_act_q;

  function automatic logic hit(input bps_req_t r, input logic [3:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // strobe decode, pins after select
  wire cs_sel = mode && !pad_e_i[2];
  wire wr_act = cs_sel && !pad_e_i[1];
  wire rd_act = cs_sel && !pad_e_i[0];
  wire ext_wr = wr_act && !wr_act_q;
  wire ext_rd = rd_act && !rd_act_q;
  wire cpu_rd_d = req_i.rd && (req_i.addr == ADDR_PIN_D);
  wire cpu_wr_d = hit(req_i, ADDR_PIN_D) || hit(req_i, ADDR_HOLD_D);
  wire set_input_overrun_flag = ext_wr && input_full_flag;
  wire [2:0] irq_ev = {set_input_overrun_flag, ext_rd, ext_wr};
  wire [7:0] stat_e = {input_full_flag, output_full_flag, input_overrun_flag, mode, 1'b0, dir_e};
  wire [2:0] pin_e_val = pad_e_i & ~analog;
  // in slave mode port D reads return the captured byte
  wire [7:0] pin_d_val = mode ? in_buf : pad_d_i;

  // outputs: port D drives on slave read or as plain output
  always_comb begin
    pad_d_o.o = hold_d;
    pad_d_o.oe = mode ? {8{rd_act}} : ~dir_d;
    pad_e_o.o = hold_e;
    pad_e_o.oe = ~dir_e;
  end

  assign irq_o = |(irq_stat & irq_mask);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // cpu side registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_d <= RST_ZERO;
      dir_d <= RST_DIR_D;
      hold_e <= 3'h0;
      dir_e <= RST_DIR_E;
      analog <= RST_ANALOG;
      mode <= 1'b0;
      irq_mask <= 3'h0;
    end else begin
      if (cpu_wr_d) begin
        hold_d <= req_i.wdata;
      end
      if (hit(req_i, ADDR_DIR_D)) begin
        dir_d <= req_i.wdata;
      end
      if (hit(req_i, ADDR_PIN_E) || hit(req_i, ADDR_HOLD_E)) begin
        hold_e <= req_i.wdata[2:0];
      end
      if (hit(req_i, ADDR_DIR_E)) begin
        dir_e <= req_i.wdata[2:0];
        mode <= req_i.wdata[BIT_MODE];
      end
      if (hit(req_i, ADDR_ANALOG)) begin
        analog <= req_i.wdata[2:0];
      end
      if (hit(req_i, ADDR_IRQ_MASK)) begin
        irq_mask <= req_i.wdata[2:0];
      end
    end
  end

  // slave port flags; set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_buf <= RST_ZERO;
      input_full_flag <= 1'b0;
      output_full_flag <= 1'b0;
      input_overrun_flag <= 1'b0;
      irq_stat <= 3'h0;
    end else begin
      if (ext_wr) begin
        in_buf <= pad_d_i;
      end
      if (ext_wr) begin
        input_full_flag <= 1'b1;
      end else if (cpu_rd_d) begin
        input_full_flag <= 1'b0;
      end
      if (cpu_wr_d && mode) begin
        output_full_flag <= 1'b1;
      end else if (ext_rd) begin
        output_full_flag <= 1'b0;
      end
      if (set_input_overrun_flag) begin
        input_overrun_flag <= 1'b1;
      end else if (hit(req_i, ADDR_DIR_E) && !req_i.wdata[BIT_INPUT_OVERRUN_FLAG]) begin
        input_overrun_flag <= 1'b0;
      end
      irq_stat <= irq_ev | (irq_stat &
        ~({3{hit(req_i, ADDR_IRQ_STAT)}} & req_i.wdata[2:0]));
    end
  end

  // read data one cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= RST_ZERO;
    end else if (req_i.rd) begin
      case (req_i.addr)
        ADDR_PIN_D: rdata_o <= pin_d_val;
        ADDR_HOLD_D: rdata_o <= hold_d;
        ADDR_DIR_D: rdata_o <= dir_d;
        ADDR_PIN_E: rdata_o <= {5'h00, pin_e_val};
        ADDR_HOLD_E: rdata_o <= {5'h00, hold_e};
        ADDR_DIR_E: rdata_o <= stat_e;
        ADDR_ANALOG: rdata_o <= {5'h00, analog};
        ADDR_IRQ_STAT: rdata_o <= {5'h00, irq_stat};
        ADDR_IRQ_MASK: rdata_o <= {5'h00, irq_mask};
        default: rdata_o <= RST_ZERO;
      endcase
    end else begin
      rdata_o <= RST_ZERO;
    end
  end

  // checks
  property p_ibf_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_wr |=> input_full_flag;
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("ibf not set");

  property p_input_overrun_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ext_wr && input_full_flag) |=> input_overrun_flag;
  endproperty
  a_input_overrun_flag: assert property (p_input_overrun_flag) else $error("overrun missed");

  property p_obf_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ext_rd && !(cpu_wr_d && mode)) |=> !output_full_flag;
  endproperty
  a_obf_clr: assert property (p_obf_clr) else $error("obf stuck");

  property p_cs_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    pad_e_i[2] |-> !ext_wr && !ext_rd;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("unselected xfer");

  property p_first_low;
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_wr |=> !ext_wr;
  endproperty
  a_first_low: assert property (p_first_low) else $error("double write");

  property p_rd_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode && rd_act) |-> pad_d_o.oe == 8'hFF;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("no drive");

  property p_dir_e;
    @(posedge clk_i) disable iff (!rst_n_i)
    pad_e_o.oe == ~dir_e;
  endproperty
  a_dir_e: assert property (p_dir_e) else $error("port e oe");

  property p_ibf_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cpu_rd_d && !ext_wr) |=> !input_full_flag;
  endproperty
  a_ibf_clr: assert property (p_ibf_clr) else $error("ibf not cleared");

  property p_bit3;
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && req_i.addr == ADDR_DIR_E) |=> !rdata_o[3];
  endproperty
  a_bit3: assert property (p_bit3) else $error("bit3 set");

  property p_input_overrun_flag_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (input_overrun_flag && !(hit(req_i, ADDR_DIR_E) && !req_i.wdata[BIT_INPUT_OVERRUN_FLAG])) |=> input_overrun_flag;
  endproperty
  a_input_overrun_flag_hold: assert property (p_input_overrun_flag_hold) else $error("input_overrun_flag lost");

  property p_obf_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cpu_wr_d && mode) |=> output_full_flag;
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("obf not set");

  property p_ibf_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    (input_full_flag && !cpu_rd_d) |=> input_full_flag;
  endproperty
  a_ibf_keep: assert property (p_ibf_keep) else $error("ibf lost");

  property p_obf_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    (output_full_flag && !ext_rd) |=> output_full_flag;
  endproperty
  a_obf_keep: assert property (p_obf_keep) else $error("obf lost");

  property p_e_out;
    @(posedge clk_i) disable iff (!rst_n_i)
    pad_e_o.o == hold_e;
  endproperty
  a_e_out: assert property (p_e_out) else $error("port e data");

  property p_e_analog;
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && req_i.addr == ADDR_PIN_E) |=>
      ((rdata_o[2:0] & $past(analog)) == 3'h0);
  endproperty
  a_e_analog: assert property (p_e_analog) else $error("analog read");

  property p_hold_e_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.rd && req_i.addr == ADDR_HOLD_E) |=>
      (rdata_o == {5'h00, $past(hold_e)});
  endproperty
  a_hold_e_rd: assert property (p_hold_e_rd) else $error("latch read");

  property p_ibf_ro;
    @(posedge clk_i) disable iff (!rst_n_i)
    (hit(req_i, ADDR_DIR_E) && !ext_wr) |=> (input_full_flag == $past(input_full_flag));
  endproperty
  a_ibf_ro: assert property (p_ibf_ro) else $error("ibf written");

  property p_obf_ro;
    @(posedge clk_i) disable iff (!rst_n_i)
    (hit(req_i, ADDR_DIR_E) && !ext_rd) |=> (output_full_flag == $past(output_full_flag));
  endproperty
  a_obf_ro: assert property (p_obf_ro) else $error("obf written");

  property p_mode_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    hit(req_i, ADDR_DIR_E) |=> (mode == $past(req_i.wdata[BIT_MODE]));
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode bit");

  property p_gpio_d;
    @(posedge clk_i) disable iff (!rst_n_i)
    !mode |-> (pad_d_o.oe == ~dir_d);
  endproperty
  a_gpio_d: assert property (p_gpio_d) else $error("port d oe");

  property p_no_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode && !rd_act) |-> (pad_d_o.oe == 8'h00);
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven");

  property p_mode_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    !mode |-> (!ext_wr && !ext_rd);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("gpio xfer");

  property p_rd_first;
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_rd |=> !ext_rd;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("double read");

  property p_wr_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_wr |=> (in_buf == $past(pad_d_i));
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("bad byte");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
    !req_i.rd |=> (rdata_o == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata stuck");

  property p_irq_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_wr |=> irq_stat[IRQ_WRITE];
  endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("write event");

  property p_rd_data;
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode && rd_act) |-> (pad_d_o.o == hold_d);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data");
endmodule : bps_port

// >>> tb/bps_ext_cpu.sv
// Purpose: external 8-bit processor on the slave port
// Assumes: strobes change just after a rising edge
// Notes: data line shows the inverse of the last byte when released
`timescale 1ns/1ps
module bps_ext_cpu (
  // clock
  input wire logic clk_i,
  // strobes {select, write, read} and data toward the port
  output logic [2:0] ctl_o,
  output logic [7:0] data_o,
  // port D as driven by the device
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i
);
  initial begin
    ctl_o = 3'h7;
    data_o = 8'h00;
  end
  task xfer(input logic wr, input logic sel, input logic [7:0] d,
            output logic [7:0] got);
    @(posedge clk_i);
    ctl_o <= {~sel, ~wr, wr};
    data_o <= wr ? d : ~data_o;
    repeat (2) @(posedge clk_i);
    got = pad_o_i & pad_oe_i;
    ctl_o <= 3'h7;
    data_o <= ~data_o;
  endtask : xfer
endmodule : bps_ext_cpu

// >>> tb/bps_port_tb.sv
// Purpose: self-checking bench for the byte port with slave control
// Assumes: register port and external processor model
// Notes: pin levels resolved from all drivers
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module bps_port_tb;
  import bps_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  bps_req_t req = '0;
  logic [7:0] rdata, got, xd;
  logic irq;
  logic [2:0] xc;
  bps_pad8_t pd;
  bps_pad3_t pe;
  int num_errors = 0;
  int checks_done = 0;
  wire logic [7:0] pin_d = (pd.o & pd.oe) | (xd & ~pd.oe);
  wire logic [2:0] pin_e = (pe.o & pe.oe) | (xc & ~pe.oe);
  always #5 clk_i = ~clk_i;
  bps_port bps_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .rdata_o(rdata), .irq_o(irq), .pad_d_i(pin_d), .pad_d_o(pd),
    .pad_e_i(pin_e), .pad_e_o(pe));
  bps_ext_cpu bps_ext_cpu_inst (.clk_i(clk_i), .ctl_o(xc), .data_o(xd),
    .pad_o_i(pd.o), .pad_oe_i(pd.oe));
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1;
    `CHK(rdata, e)
  endtask : rd
  task summarize;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_DIR_D, RST_DIR_D);
    rd(ADDR_DIR_E, 8'h07);
    rd(ADDR_ANALOG, 8'h07);
    rd(ADDR_PIN_E, 8'h00);
    `CHK(pe.oe, 3'h0)
    wr(ADDR_HOLD_E, 8'h05);
    wr(ADDR_DIR_E, 8'h0A);
    rd(ADDR_DIR_E, 8'h02);
    `CHK(pe, {3'h5, 3'h5})
    rd(ADDR_HOLD_E, 8'h05);
    wr(ADDR_PIN_E, 8'h02);
    rd(ADDR_HOLD_E, 8'h02);
    wr(ADDR_HOLD_D, 8'h3C);
    wr(ADDR_DIR_D, 8'h0F);
    #1;
    `CHK(pd, {8'h3C, 8'hF0})
    rd(ADDR_PIN_D, 8'h30);
    // slave mode
    wr(ADDR_ANALOG, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_DIR_E, 8'h17);
    bps_ext_cpu_inst.xfer(1'b1, 1'b0, 8'hC3, got);
    rd(ADDR_DIR_E, 8'h17);
    bps_ext_cpu_inst.xfer(1'b1, 1'b1, 8'hA5, got);
    rd(ADDR_DIR_E, 8'h97);
    `CHK(irq, 1'b1)
    rd(ADDR_PIN_D, 8'hA5);
    rd(ADDR_DIR_E, 8'h17);
    bps_ext_cpu_inst.xfer(1'b1, 1'b1, 8'h11, got);
    bps_ext_cpu_inst.xfer(1'b1, 1'b1, 8'h22, got);
    rd(ADDR_DIR_E, 8'hB7);
    wr(ADDR_DIR_E, 8'h17);
    rd(ADDR_DIR_E, 8'h97);
    rd(ADDR_IRQ_STAT, 8'h05);
    wr(ADDR_IRQ_MASK, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_STAT, 8'h07);
    rd(ADDR_IRQ_STAT, 8'h00);
    rd(4'hF, 8'h00);
    wr(ADDR_PIN_D, 8'h5A);
    rd(ADDR_DIR_E, 8'hD7);
    bps_ext_cpu_inst.xfer(1'b0, 1'b1, 8'h00, got);
    `CHK(got, 8'h5A)
    rd(ADDR_DIR_E, 8'h97);
    summarize();
  end
endmodule : bps_port_tb
